// [core/reset_ctrl_pkg.sv]
// Constants, register map and state layout of the reset and brown-out controller
package reset_ctrl_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_PIN_KEY = 4'h0;
    localparam logic [3:0] ADDR_FLAGS = 4'h1;
    localparam logic [3:0] ADDR_THR_KEY = 4'h2;
    localparam logic [3:0] ADDR_FILTER = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;

    // ----------------------------------------------------------------
    // Keys, codes and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] KEY_IO = 8'h55;
    localparam logic [7:0] KEY_RESET_PIN = 8'hAA;
    localparam logic [7:0] THR_1V90 = 8'h55;
    localparam logic [7:0] THR_2V20 = 8'h33;
    localparam logic [7:0] THR_2V55 = 8'h99;
    localparam logic [7:0] THR_3V15 = 8'hAA;
    localparam logic [7:0] THR_OFF = 8'hF0;
    localparam logic [7:0] PIN_KEY_RESET = 8'h55;
    localparam logic [7:0] THR_KEY_RESET = 8'h55;
    localparam logic [1:0] FILTER_RESET = 2'h1;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FLAG_KEY_CORRUPT = 3;
    localparam int FLAG_BROWNOUT = 2;
    localparam int FLAG_THR_CORRUPT = 1;
    localparam int STAT_WDT_EXPIRED = 0;
    localparam int STAT_POWERED_DOWN = 1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_HZ = 125000000;
    localparam int SLOW_OSC_HZ = 32000;
    localparam int SLOW_OSC_PERIOD_CYCLES = SYS_CLK_HZ / SLOW_OSC_HZ;
    localparam logic [7:0] FILTER_PERIODS_00 = 8'h08;
    localparam logic [7:0] FILTER_PERIODS_01 = 8'h20;
    localparam logic [7:0] FILTER_PERIODS_10 = 8'h40;
    localparam logic [7:0] FILTER_PERIODS_11 = 8'h80;
    localparam int CORRUPT_DELAY_DEFAULT = 16;
    localparam int RESET_PULSE_DEFAULT = 16;

    // ----------------------------------------------------------------
    // State of the controller
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] pin_key;
        logic [7:0] thr_key;
        logic [1:0] filter_sel;
        logic key_corrupt_flag;
        logic brownout_flag;
        logic threshold_corrupt_flag;
        logic watchdog_expired_flag;
        logic powered_down_flag;
        logic [7:0] rdata;
        logic [15:0] corrupt_cnt;
        logic [15:0] tick_cnt;
        logic [7:0] low_cnt;
        logic [15:0] pulse_cnt;
        logic device_reset;
        logic warm_reset;
        logic reset_pin_selected;
        logic brownout_enable;
        logic [1:0] brownout_level;
    } ctrl_state_t;

endpackage : reset_ctrl_pkg

// [core/reset_source_and_brownout_control.sv]
// Reset source bookkeeping, keyed reset-pin select and brown-out filter
// What this block does
// - Pin low while configured for reset resets the device, restarting at address zero.
// - Pin key 55h selects general I/O, AAh selects the reset-pin function.
// - Any other pin key value causes a full reset after the corruption delay.
// - Pin key corruption reset sets flag bit 3; only writing zero clears it.
// - Every reset restores the pin key to 55h, except the watchdog warm reset.
// - Reset-pin selection overrides every other shared function on that pin.
// - Low supply resets only when it lasts longer than the selected filter width.
// - Brown-out reset sets flag bit 2; only writing zero clears it.
// - Threshold codes 55h, 33h, 99h, AAh pick a level; F0h disables detection.
// - Undefined threshold code resets after the delay and restores the power-on code.
// - Threshold code corruption reset sets flag bit 1; only writing zero clears it.
// - A genuine brown-out reset keeps the threshold register contents.
// - Brown-out detection is off during sleep or idle mode.
// - Filter field picks 8, 32, 64 or 128 slow-oscillator periods.
// - Unimplemented flag and filter register bits read as zero.
// - Watchdog time-out in normal mode resets and sets the expired flag.
// - Watchdog time-out in low power clears PC and SP, sets expired and powered-down.
// - The slow oscillator timing the filter is taken as about 32 kHz.
`timescale 1ns/1ns

module reset_source_and_brownout_control
    import reset_ctrl_pkg::*;
#(
    parameter int CORRUPT_DELAY_CYCLES = CORRUPT_DELAY_DEFAULT,
    parameter int RESET_PULSE_CYCLES = RESET_PULSE_DEFAULT,
    parameter int SLOW_TICK_CYCLES = SLOW_OSC_PERIOD_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic ext_reset_pin_n_in,
    input wire logic low_supply_in,
    input wire logic low_power_mode_in,
    input wire logic watchdog_timeout_in,
    output logic device_reset_out,
    output logic warm_reset_out,
    output logic reset_pin_selected_out,
    output logic brownout_enable_out,
    output logic [1:0] brownout_level_out,
    output logic watchdog_expired_flag_out,
    output logic powered_down_flag_out
);
    import reset_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    localparam logic [15:0] CORRUPT_LAST = 16'(CORRUPT_DELAY_CYCLES - 1);
    localparam logic [15:0] PULSE_LEN = 16'(RESET_PULSE_CYCLES);
    localparam logic [15:0] TICK_LAST = 16'(SLOW_TICK_CYCLES - 1);

    ctrl_state_t st;
    ctrl_state_t next_st;

    // ----------------------------------------------------------------
    // Decodes
    // ----------------------------------------------------------------
    logic pin_key_valid;
    logic thr_key_valid;
    logic thr_known_level;
    logic [1:0] level_code;
    logic [7:0] filter_target;

    always_comb begin
        pin_key_valid = (st.pin_key == KEY_IO) || (st.pin_key == KEY_RESET_PIN);
        thr_known_level = 1'b1;
        level_code = 2'h0;
        unique case (st.thr_key)
            THR_1V90: level_code = 2'h0;
            THR_2V20: level_code = 2'h1;
            THR_2V55: level_code = 2'h2;
            THR_3V15: level_code = 2'h3;
            default: thr_known_level = 1'b0;
        endcase
        thr_key_valid = thr_known_level || (st.thr_key == THR_OFF);
        unique case (st.filter_sel)
            2'h0: filter_target = FILTER_PERIODS_00;
            2'h1: filter_target = FILTER_PERIODS_01;
            2'h2: filter_target = FILTER_PERIODS_10;
            2'h3: filter_target = FILTER_PERIODS_11;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic corrupt_fire;
    logic slow_tick;
    logic detect_on;
    logic brownout_fire;
    logic pin_fire;
    logic wdt_normal;
    logic wdt_sleep;
    logic full_reset;

    always_comb begin
        next_st = st;

        // Both key checks share one delay counter; a key that heals itself
        // before the delay runs out cancels the pending reset.
        corrupt_fire = 1'b0;
        if (pin_key_valid && thr_key_valid) begin
            next_st.corrupt_cnt = 16'h0000;
        end else if (st.corrupt_cnt == CORRUPT_LAST) begin
            corrupt_fire = 1'b1;
            next_st.corrupt_cnt = 16'h0000;
        end else begin
            next_st.corrupt_cnt = st.corrupt_cnt + 16'h0001;
        end

        // Slow oscillator periods derived from the system clock
        slow_tick = (st.tick_cnt == TICK_LAST);
        next_st.tick_cnt = slow_tick ? 16'h0000 : st.tick_cnt + 16'h0001;

        // Glitch filter: the count restarts whenever supply recovers
        detect_on = thr_known_level && !low_power_mode_in;
        brownout_fire = 1'b0;
        if (!(low_supply_in && detect_on)) begin
            next_st.low_cnt = 8'h00;
        end else if (slow_tick) begin
            if (st.low_cnt + 8'h01 >= filter_target) begin
                brownout_fire = 1'b1;
                next_st.low_cnt = 8'h00;
            end else begin
                next_st.low_cnt = st.low_cnt + 8'h01;
            end
        end

        pin_fire = !ext_reset_pin_n_in && (st.pin_key == KEY_RESET_PIN);
        wdt_normal = watchdog_timeout_in && !low_power_mode_in;
        wdt_sleep = watchdog_timeout_in && low_power_mode_in;
        full_reset = corrupt_fire || brownout_fire || pin_fire || wdt_normal;

        // Register writes
        if (wr_in) begin
            unique case (addr_in)
                ADDR_PIN_KEY: next_st.pin_key = wdata_in;
                ADDR_THR_KEY: next_st.thr_key = wdata_in;
                ADDR_FILTER: next_st.filter_sel = wdata_in[1:0];
                ADDR_FLAGS: begin
                    // Writing one leaves a flag alone; only zero clears
                    next_st.key_corrupt_flag = st.key_corrupt_flag && wdata_in[FLAG_KEY_CORRUPT];
                    next_st.brownout_flag = st.brownout_flag && wdata_in[FLAG_BROWNOUT];
                    next_st.threshold_corrupt_flag =
                        st.threshold_corrupt_flag && wdata_in[FLAG_THR_CORRUPT];
                end
                ADDR_STATUS: begin
                    next_st.watchdog_expired_flag =
                        st.watchdog_expired_flag && wdata_in[STAT_WDT_EXPIRED];
                    next_st.powered_down_flag =
                        st.powered_down_flag && wdata_in[STAT_POWERED_DOWN];
                end
                default: ;
            endcase
        end

        // Reset effects come after writes so that a set beats a clear
        if (full_reset) begin
            next_st.pin_key = PIN_KEY_RESET;
            next_st.filter_sel = FILTER_RESET;
            next_st.low_cnt = 8'h00;
            next_st.corrupt_cnt = 16'h0000;
            next_st.pulse_cnt = PULSE_LEN;
            if (!brownout_fire || corrupt_fire || pin_fire || wdt_normal) begin
                next_st.thr_key = THR_KEY_RESET;
            end
        end
        if (corrupt_fire && !pin_key_valid) begin
            next_st.key_corrupt_flag = 1'b1;
        end
        if (corrupt_fire && !thr_key_valid) begin
            next_st.threshold_corrupt_flag = 1'b1;
        end
        if (brownout_fire) begin
            next_st.brownout_flag = 1'b1;
        end
        if (wdt_normal) begin
            next_st.watchdog_expired_flag = 1'b1;
        end
        if (wdt_sleep) begin
            next_st.watchdog_expired_flag = 1'b1;
            next_st.powered_down_flag = 1'b1;
        end

        // Reset pulse holds the core down; a held pin does not extend it, since the reset returns the pin key to 55h
        if (!full_reset && st.pulse_cnt != 16'h0000) begin
            next_st.pulse_cnt = st.pulse_cnt - 16'h0001;
        end
        next_st.device_reset = full_reset || (st.pulse_cnt > 16'h0001);
        // Only PC and SP clear; the rest of the core keeps running state
        next_st.warm_reset = wdt_sleep && !full_reset;

        next_st.reset_pin_selected = (next_st.pin_key == KEY_RESET_PIN);
        next_st.brownout_enable = detect_on;
        next_st.brownout_level = level_code;

        // Read data stands in the cycle after the strobe only
        next_st.rdata = 8'h00;
        if (rd_in) begin
            unique case (addr_in)
                ADDR_PIN_KEY: next_st.rdata = st.pin_key;
                ADDR_THR_KEY: next_st.rdata = st.thr_key;
                ADDR_FILTER: next_st.rdata = {6'h00, st.filter_sel};
                ADDR_FLAGS: begin
                    next_st.rdata = 8'h00;
                    next_st.rdata[FLAG_KEY_CORRUPT] = st.key_corrupt_flag;
                    next_st.rdata[FLAG_BROWNOUT] = st.brownout_flag;
                    next_st.rdata[FLAG_THR_CORRUPT] = st.threshold_corrupt_flag;
                end
                ADDR_STATUS: begin
                    next_st.rdata[STAT_WDT_EXPIRED] = st.watchdog_expired_flag;
                    next_st.rdata[STAT_POWERED_DOWN] = st.powered_down_flag;
                end
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.pin_key <= PIN_KEY_RESET;
            st.thr_key <= THR_KEY_RESET;
            st.filter_sel <= FILTER_RESET;
            st.brownout_enable <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_out = st.rdata;
    assign device_reset_out = st.device_reset;
    assign warm_reset_out = st.warm_reset;
    assign reset_pin_selected_out = st.reset_pin_selected;
    assign brownout_enable_out = st.brownout_enable;
    assign brownout_level_out = st.brownout_level;
    assign watchdog_expired_flag_out = st.watchdog_expired_flag;
    assign powered_down_flag_out = st.powered_down_flag;

endmodule : reset_source_and_brownout_control

// [verif/reset_ctrl_checker.sv]
// Port-level checks for the reset and brown-out controller
`timescale 1ns/1ns
module reset_ctrl_checker
    import reset_ctrl_pkg::*;
#(
    parameter int RESET_PULSE_CYCLES = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic ext_reset_pin_n_in,
    input wire logic low_power_mode_in,
    input wire logic watchdog_timeout_in,
    input wire logic device_reset_out,
    input wire logic warm_reset_out,
    input wire logic reset_pin_selected_out,
    input wire logic brownout_enable_out,
    input wire logic watchdog_expired_flag_out,
    input wire logic powered_down_flag_out
);
    logic [15:0] run_cnt;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Length of the current full-reset pulse
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_cnt <= 16'h0000;
        end else begin
            run_cnt <= device_reset_out ? run_cnt + 16'h0001 : 16'h0000;
        end
    end
    sequence sleep_wdt_s;
        watchdog_timeout_in && low_power_mode_in;
    endsequence
    sequence warm_only_s;
        warm_reset_out && !device_reset_out && watchdog_expired_flag_out
            && powered_down_flag_out ##1 !warm_reset_out;
    endsequence
    a_sleep_warm_reset: assert property (sleep_wdt_s |=> warm_only_s)
        else $error("warm reset after sleep watchdog wrong");
    a_wdt_full_reset: assert property (watchdog_timeout_in && !low_power_mode_in
        |=> device_reset_out && watchdog_expired_flag_out) else $error("watchdog reset missing");
    a_pin_reset_fires: assert property (!ext_reset_pin_n_in && reset_pin_selected_out
        |=> device_reset_out) else $error("pin reset missing");
    a_pin_key_select: assert property (wr_in && addr_in == ADDR_PIN_KEY
        && wdata_in == KEY_RESET_PIN && !device_reset_out |-> ##[1:2] reset_pin_selected_out)
        else $error("reset pin not selected");
    a_sleep_bo_off: assert property (low_power_mode_in [*2] |-> !brownout_enable_out)
        else $error("brown-out enabled in low power");
    // run_cnt already counts every high cycle at the fall, so the added one lets a pulse one cycle short pass
    a_pulse_length: assert property ($fell(device_reset_out)
        |-> run_cnt + 16'h0001 >= 16'(RESET_PULSE_CYCLES))
        else $error("reset pulse too short");
    a_idle_rdata_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside read cycle");
    a_flag_pad_zero: assert property (rd_in && addr_in == ADDR_FLAGS
        |=> rdata_out[7:4] == 4'h0 && !rdata_out[0]) else $error("flag pad bits set");
    a_filter_pad_zero: assert property (rd_in && addr_in == ADDR_FILTER
        |=> rdata_out[7:2] == 6'h00) else $error("filter pad bits set");
endmodule : reset_ctrl_checker

// [verif/reset_ctrl_partner.sv]
// External reset network and supply comparator model
`timescale 1ns/1ns
module reset_ctrl_partner (
    input wire logic clk_in,
    input wire logic pin_hold_in,
    input wire logic dip_go_in,
    input wire logic [7:0] dip_len_in,
    output logic ext_reset_pin_n_out,
    output logic low_supply_out
);
    logic [7:0] left = 8'h00;
    always @(posedge clk_in) begin
        if (dip_go_in) begin
            left <= dip_len_in;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    // The RC pull-up returns the pin high once nothing holds it
    assign ext_reset_pin_n_out = !pin_hold_in;
    assign low_supply_out = (left != 8'h00);
endmodule : reset_ctrl_partner

// [verif/reset_source_and_brownout_control_tb.sv]
// Testbench for the reset and brown-out controller
`timescale 1ns/1ns
module reset_source_and_brownout_control_tb;
    import reset_ctrl_pkg::*;
    logic clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, pin_hold = 0, dip_go = 0;
    logic lp = 0, wdt = 0, pin_n, low, dev_rst, sel, bo_en, hit;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00, rdata_out, dip_len = 8'h00;
    logic [7:0] codes [4] = '{THR_1V90, THR_2V20, THR_2V55, THR_3V15};
    logic [1:0] level;
    int err_total = 0, comparisons = 0, first;
    reset_source_and_brownout_control #(.CORRUPT_DELAY_CYCLES(4), .RESET_PULSE_CYCLES(4),
        .SLOW_TICK_CYCLES(4)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .ext_reset_pin_n_in(pin_n), .low_supply_in(low), .low_power_mode_in(lp),
        .watchdog_timeout_in(wdt), .device_reset_out(dev_rst), .warm_reset_out(),
        .reset_pin_selected_out(sel), .brownout_enable_out(bo_en),
        .brownout_level_out(level), .watchdog_expired_flag_out(),
        .powered_down_flag_out());
    reset_ctrl_partner far_side (.clk_in(clk_in), .pin_hold_in(pin_hold), .dip_go_in(dip_go),
        .dip_len_in(dip_len), .ext_reset_pin_n_out(pin_n), .low_supply_out(low));
    initial forever #4 clk_in = ~clk_in;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        check("register", rdata_out, exp);
    endtask : chk_rd
    // Cycles from now to the first full reset; hit stays 0 when none comes
    task automatic wait_rst(input int lim);
        hit = 1'b0;
        first = 0;
        for (int i = 1; i <= lim; i++) begin
            @(posedge clk_in);
            #1;
            if (dev_rst === 1'b1 && hit === 1'b0) begin
                hit = 1'b1;
                first = i;
            end
        end
    endtask : wait_rst
    task automatic dip(input logic [7:0] n, input int lim);
        @(posedge clk_in);
        dip_len <= n;
        dip_go <= 1'b1;
        @(posedge clk_in);
        dip_go <= 1'b0;
        wait_rst(lim);
    endtask : dip
    task automatic give_verdict();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk_rd(ADDR_PIN_KEY, PIN_KEY_RESET);
        chk_rd(ADDR_FLAGS, 8'h00);
        chk_rd(ADDR_THR_KEY, THR_KEY_RESET);
        chk_rd(ADDR_FILTER, {6'h00, FILTER_RESET});
        chk_rd(4'h7, 8'h00);
        wr(ADDR_FILTER, 8'hFF);
        chk_rd(ADDR_FILTER, 8'h03);
        wr(ADDR_FLAGS, 8'hFF);
        chk_rd(ADDR_FLAGS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_THR_KEY, codes[i]);
            repeat (3) @(posedge clk_in);
            check("level", {5'h00, bo_en, level}, {6'h01, i[1:0]});
        end
        wr(ADDR_THR_KEY, THR_OFF);
        repeat (3) @(posedge clk_in);
        check("enable", {7'h00, bo_en}, 8'h00);
        wr(ADDR_PIN_KEY, 8'h12);
        wait_rst(20);
        check("corrupt delay", first[7:0], 8'h04);
        chk_rd(ADDR_PIN_KEY, KEY_IO);
        wr(ADDR_FLAGS, 8'h08);
        chk_rd(ADDR_FLAGS, 8'h08);
        wr(ADDR_FLAGS, 8'h00);
        chk_rd(ADDR_FLAGS, 8'h00);
        wr(ADDR_THR_KEY, 8'h3C);
        wait_rst(20);
        check("threshold delay", first[7:0], 8'h04);
        chk_rd(ADDR_THR_KEY, THR_KEY_RESET);
        chk_rd(ADDR_FLAGS, 8'h02);
        wr(ADDR_FLAGS, 8'h00);
        pin_hold <= 1'b1;
        wait_rst(6);
        check("pin as io", {7'h00, hit}, 8'h00);
        pin_hold <= 1'b0;
        wr(ADDR_PIN_KEY, KEY_RESET_PIN);
        repeat (3) @(posedge clk_in);
        check("pin select", {7'h00, sel}, 8'h01);
        pin_hold <= 1'b1;
        repeat (3) @(posedge clk_in);
        pin_hold <= 1'b0;
        wait_rst(10);
        check("pin reset", {6'h00, hit, sel}, 8'h02);
        wr(ADDR_THR_KEY, THR_2V20);
        wr(ADDR_FILTER, 8'h03);
        dip(8'd200, 260);
        check("long filter", {7'h00, hit}, 8'h00);
        wr(ADDR_FILTER, 8'h00);
        dip(8'd20, 40);
        check("short dip", {7'h00, hit}, 8'h00);
        lp <= 1'b1;
        dip(8'd60, 80);
        check("sleep dip", {7'h00, hit}, 8'h00);
        lp <= 1'b0;
        dip(8'd60, 80);
        check("brown-out", {7'h00, hit}, 8'h01);
        chk_rd(ADDR_FLAGS, 8'h04);
        chk_rd(ADDR_THR_KEY, THR_2V20);
        @(posedge clk_in);
        wdt <= 1'b1;
        @(posedge clk_in);
        wdt <= 1'b0;
        wait_rst(8);
        chk_rd(ADDR_STATUS, 8'h01);
        wr(ADDR_STATUS, 8'h00);
        wr(ADDR_PIN_KEY, KEY_RESET_PIN);
        lp <= 1'b1;
        wdt <= 1'b1;
        @(posedge clk_in);
        wdt <= 1'b0;
        wait_rst(8);
        check("warm only", {7'h00, hit}, 8'h00);
        chk_rd(ADDR_STATUS, 8'h03);
        chk_rd(ADDR_PIN_KEY, KEY_RESET_PIN);
        lp <= 1'b0;
        give_verdict();
    end
endmodule : reset_source_and_brownout_control_tb
bind reset_source_and_brownout_control reset_ctrl_checker #(
    .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ext_reset_pin_n_in(ext_reset_pin_n_in),
    .low_power_mode_in(low_power_mode_in), .watchdog_timeout_in(watchdog_timeout_in),
    .device_reset_out(device_reset_out), .warm_reset_out(warm_reset_out),
    .reset_pin_selected_out(reset_pin_selected_out),
    .brownout_enable_out(brownout_enable_out),
    .watchdog_expired_flag_out(watchdog_expired_flag_out),
    .powered_down_flag_out(powered_down_flag_out));
